// ==== hdl/flash_self_program_sections.sv ====
// Self-programming section and protection control for the program Flash.
// Assumes CPU-side strobes are on clk; fuse pins are asynchronous levels.
`timescale 1ns/1ps
module flash_self_program_sections
    import self_prog_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic [FLASH_WORD_BITS-1:0] exec_addr,
    input  wire logic                       spm_req,
    input  wire logic [1:0]                 spm_cmd,
    input  wire logic [Z_BITS-1:0]          spm_pointer,
    input  wire logic [3:0]                 spm_lock_data,
    input  wire logic                       rww_clear_req,
    input  wire logic                       prog_if_lock_req,
    input  wire logic [3:0]                 prog_if_lock_data,
    input  wire logic                       chip_erase,
    input  wire logic [1:0]                 boot_size_fuses,
    input  wire logic                       boot_reset_select_fuse,
    input  wire logic                       flash_done,
    output logic                            flash_start,
    output logic [1:0]                      flash_cmd,
    output logic [PAGE_BITS-1:0]            flash_page,
    output logic                            cpu_stall,
    output logic                            rww_read_enable,
    output logic                            rww_region_busy_flag,
    output logic                            spm_refused,
    output logic                            spm_busy,
    output logic [FLASH_WORD_BITS-1:0]      reset_vector,
    output logic [FLASH_WORD_BITS-1:0]      boot_start,
    output logic [3:0]                      boot_lock_bits
);

    section_if s ();

    section_decode u_dec (
        .s (s)
    );

    // Fuse synchronisers
    logic [1:0] size_meta_r;
    logic [1:0] size_r;
    logic       brst_meta_r;
    logic       brst_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            size_meta_r <= SIZE_FUSE_RESET;
            size_r      <= SIZE_FUSE_RESET;
            brst_meta_r <= BRST_FUSE_RESET;
            brst_r      <= BRST_FUSE_RESET;
        end else begin
            size_meta_r <= boot_size_fuses;
            size_r      <= size_meta_r;
            brst_meta_r <= boot_reset_select_fuse;
            brst_r      <= brst_meta_r;
        end
    end

    // Decoder hookup; the pointer's whole word address field (page and word bits) names the target
    logic [FLASH_WORD_BITS-1:0] req_word;

    assign req_word      = spm_pointer[Z_PAGE_MSB:Z_WORD_LSB];
    assign s.boot_size   = size_r;
    assign s.exec_addr   = exec_addr;
    assign s.target_addr = req_word;

    // Sequencer state
    seq_state_type            state_r;
    seq_state_type            state_nxt;
    logic [PAGE_BITS-1:0]     page_r;
    logic [PAGE_BITS-1:0]     page_nxt;
    logic [1:0]               cmd_r;
    logic [1:0]               cmd_nxt;
    logic                     tgt_rww_r;
    logic                     tgt_rww_nxt;
    logic                     start_r;
    logic                     start_nxt;
    logic                     refused_r;
    logic                     refused_nxt;
    logic                     busy_flag_r;
    logic                     busy_flag_nxt;
    logic [1:0]               app_lock_r;
    logic [1:0]               app_lock_nxt;
    logic [1:0]               boot_lock_r;
    logic [1:0]               boot_lock_nxt;
    logic [FLASH_WORD_BITS-1:0] vector_r;
    logic [FLASH_WORD_BITS-1:0] vector_nxt;

    logic from_boot;
    logic is_page_op;
    logic write_locked;

    always_comb begin
        from_boot     = s.exec_in_boot;
        is_page_op    = (spm_cmd == CMD_PAGE_ERASE) || (spm_cmd == CMD_PAGE_WRITE);
        // Each section has its own write lock
        write_locked  = s.target_in_boot ? ~boot_lock_r[LOCK_WRITE_BIT]
                                         : ~app_lock_r[LOCK_WRITE_BIT];

        state_nxt     = state_r;
        page_nxt      = page_r;
        cmd_nxt       = cmd_r;
        tgt_rww_nxt   = tgt_rww_r;
        start_nxt     = 1'b0;
        refused_nxt   = 1'b0;
        busy_flag_nxt = busy_flag_r;
        app_lock_nxt  = app_lock_r;
        boot_lock_nxt = boot_lock_r;

        // Software clear, ignored while an READ_WHILE_WRITE_REGION operation runs
        if (rww_clear_req && !(state_r == ST_RUN && tgt_rww_r)) begin
            busy_flag_nxt = 1'b0;
        end

        case (state_r)
            ST_IDLE: begin
                if (spm_req) begin
                    if (!from_boot) begin
                        refused_nxt = 1'b1;
                    end else if (spm_cmd == CMD_LOCK_WRITE) begin
                        app_lock_nxt  = app_lock_r & spm_lock_data[1:0];
                        boot_lock_nxt = boot_lock_r & spm_lock_data[3:2];
                    end else if (is_page_op && !write_locked) begin
                        // Any page whose section is not write locked is reachable from boot; page latched here
                        page_nxt    = spm_pointer[Z_PAGE_MSB:Z_PAGE_LSB];
                        cmd_nxt     = spm_cmd;
                        tgt_rww_nxt = s.target_in_rww;
                        start_nxt   = 1'b1;
                        state_nxt   = ST_RUN;
                        if (s.target_in_rww) begin
                            busy_flag_nxt = 1'b1;
                        end
                    end else begin
                        refused_nxt = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (spm_req) begin
                    refused_nxt = 1'b1;
                end
                if (flash_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        // Programming interface may also program lock bits
        if (prog_if_lock_req) begin
            app_lock_nxt  = app_lock_nxt & prog_if_lock_data[1:0];
            boot_lock_nxt = boot_lock_nxt & prog_if_lock_data[3:2];
        end
        // Only chip erase or reset returns them to unprogrammed
        if (chip_erase) begin
            app_lock_nxt  = LOCK_RESET;
            boot_lock_nxt = LOCK_RESET;
        end

        // Reset target per boot reset fuse
        vector_nxt = brst_r ? APP_RESET_ADDR : s.boot_start;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r     <= ST_IDLE;
            page_r      <= '0;
            cmd_r       <= CMD_NONE;
            tgt_rww_r   <= 1'b0;
            start_r     <= 1'b0;
            refused_r   <= 1'b0;
            busy_flag_r <= 1'b0;
            app_lock_r  <= LOCK_RESET;
            boot_lock_r <= LOCK_RESET;
            vector_r    <= APP_RESET_ADDR;
        end else begin
            state_r     <= state_nxt;
            page_r      <= page_nxt;
            cmd_r       <= cmd_nxt;
            tgt_rww_r   <= tgt_rww_nxt;
            start_r     <= start_nxt;
            refused_r   <= refused_nxt;
            busy_flag_r <= busy_flag_nxt;
            app_lock_r  <= app_lock_nxt;
            boot_lock_r <= boot_lock_nxt;
            vector_r    <= vector_nxt;
        end
    end

    // Flash array side: page address only, word bits unused for page ops
    assign flash_start          = start_r;
    assign flash_cmd            = cmd_r;
    assign flash_page           = page_r;

    // Core side
    assign spm_busy             = (state_r == ST_RUN);
    assign cpu_stall            = spm_busy && !tgt_rww_r;
    assign rww_read_enable      = !busy_flag_r && !spm_busy;
    assign rww_region_busy_flag = busy_flag_r;
    assign spm_refused          = refused_r;
    assign reset_vector         = vector_r;
    assign boot_start           = s.boot_start;
    assign boot_lock_bits       = {boot_lock_r, app_lock_r};

endmodule // flash_self_program_sections

// ==== hdl/section_decode.sv ====
// Section decoder: boot/application split from fuses, fixed READ_WHILE_WRITE_REGION/NO_READ_WHILE_WRITE_REGION split.
// Assumes fuse value is already synchronised by the caller.
`timescale 1ns/1ps
module section_decode
    import self_prog_pkg::*;
(
    section_if.dec s
);

    function automatic logic [FLASH_WORD_BITS-1:0] boot_start_of(input logic [1:0] sz);
        case (sz)
            2'h0:    boot_start_of = BOOT_START_SZ0;
            2'h1:    boot_start_of = BOOT_START_SZ1;
            2'h2:    boot_start_of = BOOT_START_SZ2;
            default: boot_start_of = BOOT_START_SZ3;
        endcase
    endfunction

    function automatic logic in_boot(input logic [FLASH_WORD_BITS-1:0] a,
                                     input logic [FLASH_WORD_BITS-1:0] start);
        in_boot = (a >= start);
    endfunction

    // Boundary follows the fuses; every start lies at or above STALL_REGION_START
    assign s.boot_start     = boot_start_of(s.boot_size);
    assign s.exec_in_boot   = in_boot(s.exec_addr, s.boot_start);
    assign s.target_in_boot = in_boot(s.target_addr, s.boot_start);
    // Fixed region split, independent of the fuses
    assign s.target_in_rww  = (s.target_addr < STALL_REGION_START);

endmodule // section_decode

// ==== hdl/section_if.sv ====
// Interface between the sequencer and the section decoder.
// Assumes both ends run on the same clock; all signals are combinational.
`timescale 1ns/1ps
interface section_if;
    import self_prog_pkg::*;

    logic [1:0]                 boot_size;
    logic [FLASH_WORD_BITS-1:0] exec_addr;
    logic [FLASH_WORD_BITS-1:0] target_addr;
    logic [FLASH_WORD_BITS-1:0] boot_start;
    logic                       exec_in_boot;
    logic                       target_in_boot;
    logic                       target_in_rww;

    modport seq (
        output boot_size, exec_addr, target_addr,
        input  boot_start, exec_in_boot, target_in_boot, target_in_rww
    );

    modport dec (
        input  boot_size, exec_addr, target_addr,
        output boot_start, exec_in_boot, target_in_boot, target_in_rww
    );
endinterface // section_if

// ==== hdl/self_prog_pkg.sv ====
// Constants and types for the self-programming section control block.
// Assumes one 250 MHz clock and a word-addressed program Flash.
package self_prog_pkg;

    // Flash geometry, in 16-bit words
    localparam int FLASH_WORD_BITS = 13;
    localparam int PAGE_WORD_BITS  = 6;
    localparam int PAGE_BITS       = FLASH_WORD_BITS - PAGE_WORD_BITS;
    localparam int Z_BITS          = 16;
    // Word address field inside the byte pointer
    localparam int Z_WORD_LSB      = 1;
    localparam int Z_PAGE_LSB      = Z_WORD_LSB + PAGE_WORD_BITS;
    localparam int Z_PAGE_MSB      = Z_WORD_LSB + FLASH_WORD_BITS - 1;

    // Fixed start of the no-read-while-write region
    localparam logic [FLASH_WORD_BITS-1:0] STALL_REGION_START = 13'h1C00;

    // Boot section start per boot size fuse setting
    localparam logic [FLASH_WORD_BITS-1:0] BOOT_START_SZ0 = 13'h1C00;
    localparam logic [FLASH_WORD_BITS-1:0] BOOT_START_SZ1 = 13'h1E00;
    localparam logic [FLASH_WORD_BITS-1:0] BOOT_START_SZ2 = 13'h1F00;
    localparam logic [FLASH_WORD_BITS-1:0] BOOT_START_SZ3 = 13'h1F80;

    // Application reset address
    localparam logic [FLASH_WORD_BITS-1:0] APP_RESET_ADDR = 13'h0000;

    // Lock bit pair: bit 1 = read lock, bit 0 = write lock; 1 = unprogrammed
    localparam int              LOCK_WRITE_BIT = 0;
    localparam int              LOCK_READ_BIT  = 1;
    localparam logic [1:0]      LOCK_RESET     = 2'h3;

    // Reset values of fuse synchronisers (unprogrammed)
    localparam logic [1:0]      SIZE_FUSE_RESET = 2'h3;
    localparam logic            BRST_FUSE_RESET = 1'b1;

    // Store-program commands
    typedef enum logic [1:0] {
        CMD_PAGE_ERASE = 2'h0,
        CMD_PAGE_WRITE = 2'h1,
        CMD_LOCK_WRITE = 2'h2,
        CMD_NONE       = 2'h3
    } spm_cmd_type;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } seq_state_type;

endpackage

// ==== sim/flash_array_model.sv ====
// Behavioural program Flash array answering page erase and write starts.
// Assumes one-cycle start pulses on clk; latency is set by the bench.
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       flash_start,
    input  wire logic [6:0] flash_page,
    input  wire logic [7:0] latency,
    output logic            flash_done,
    output logic [6:0]      last_page
);
    logic [7:0] left_r;
    always_ff @(posedge clk) begin
        flash_done <= 1'b0;
        if (reset) begin
            left_r <= 8'h00;
        end else if (flash_start) begin
            left_r    <= latency;
            last_page <= flash_page;
        end else if (left_r != 8'h00) begin
            left_r     <= left_r - 8'h01;
            flash_done <= (left_r == 8'h01);
        end
    end
endmodule // flash_array_model

// ==== sim/flash_sections_checker.sv ====
// Concurrent checks on the self-programming section control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module flash_sections_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [12:0] exec_addr,
    input wire logic        spm_req,
    input wire logic        rww_clear_req,
    input wire logic        chip_erase,
    input wire logic        flash_start,
    input wire logic [6:0]  flash_page,
    input wire logic        cpu_stall,
    input wire logic        rww_read_enable,
    input wire logic        rww_region_busy_flag,
    input wire logic        spm_refused,
    input wire logic        spm_busy,
    input wire logic [12:0] boot_start,
    input wire logic [3:0]  boot_lock_bits
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Request issued from application code
    sequence s_app_request;
        spm_req && !spm_busy && !rww_clear_req && (exec_addr < boot_start);
    endsequence
    // READ_WHILE_WRITE_REGION page operation running
    sequence s_rww_op;
        spm_busy && !cpu_stall;
    endsequence

    property p_app_refused;
        s_app_request |=> spm_refused && !flash_start && $stable(rww_region_busy_flag);
    endproperty
    property p_no_read_while_write_region_stall;
        flash_start |-> (cpu_stall == (flash_page >= 7'h70));
    endproperty
    property p_rww_running;
        flash_start && (flash_page < 7'h70) |-> !cpu_stall && rww_region_busy_flag;
    endproperty
    property p_no_rww_read;
        spm_busy || rww_region_busy_flag |-> !rww_read_enable;
    endproperty
    property p_clear_refused;
        s_rww_op |=> rww_region_busy_flag;
    endproperty
    property p_flag_holds;
        rww_region_busy_flag && !rww_clear_req |=> rww_region_busy_flag;
    endproperty
    property p_page_latched;
        spm_busy && !flash_start |-> $stable(flash_page);
    endproperty
    property p_boot_in_no_read_while_write_region;
        boot_start >= 13'h1C00;
    endproperty
    property p_locks_only_program;
        !chip_erase |=> (boot_lock_bits & ~$past(boot_lock_bits)) == 4'h0;
    endproperty
    property p_erase_unlocks;
        chip_erase |=> boot_lock_bits == 4'hF;
    endproperty

    a_app_refused: assert property (p_app_refused) else $error("app request not refused");
    a_no_read_while_write_region_stall: assert property (p_no_read_while_write_region_stall) else $error("stall wrong at start");
    a_rww_running: assert property (p_rww_running) else $error("rww op stalls core");
    a_no_rww_read: assert property (p_no_rww_read) else $error("rww read while blocked");
    a_clear_refused: assert property (p_clear_refused) else $error("flag cleared mid op");
    a_flag_holds: assert property (p_flag_holds) else $error("flag dropped unasked");
    a_page_latched: assert property (p_page_latched) else $error("page moved mid op");
    a_boot_in_no_read_while_write_region: assert property (p_boot_in_no_read_while_write_region) else $error("boot below no_read_while_write_region");
    a_locks_only_program: assert property (p_locks_only_program) else $error("lock released");
    a_erase_unlocks: assert property (p_erase_unlocks) else $error("erase kept locks");
endmodule // flash_sections_checker

// ==== sim/tb_top.sv ====
// Self-checking bench for the self-programming section control block.
// Assumes the bench plays boot loader software; the array model answers.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, reset = 1'b1, spm_req = 1'b0, rww_clear_req = 1'b0;
    logic        prog_if_lock_req = 1'b0, chip_erase = 1'b0, boot_reset_select_fuse = 1'b1;
    logic [12:0] exec_addr = 13'h0000;
    logic [1:0]  spm_cmd = 2'h3, boot_size_fuses = 2'h3;
    logic [15:0] spm_pointer = 16'h0000;
    logic [3:0]  spm_lock_data = 4'hF, prog_if_lock_data = 4'hF, boot_lock_bits;
    logic [7:0]  latency = 8'h14;
    logic        flash_done, flash_start, cpu_stall, rww_read_enable;
    logic        rww_region_busy_flag, spm_refused, spm_busy;
    logic [1:0]  flash_cmd;
    logic [6:0]  flash_page, last_page;
    logic [12:0] reset_vector, boot_start;
    logic [12:0] bstart [4] = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
    int          mismatches = 0, compares = 0;

    flash_self_program_sections dut (.clk(clk), .reset(reset), .exec_addr(exec_addr),
        .spm_req(spm_req), .spm_cmd(spm_cmd), .spm_pointer(spm_pointer),
        .spm_lock_data(spm_lock_data), .rww_clear_req(rww_clear_req),
        .prog_if_lock_req(prog_if_lock_req), .prog_if_lock_data(prog_if_lock_data),
        .chip_erase(chip_erase), .boot_size_fuses(boot_size_fuses),
        .boot_reset_select_fuse(boot_reset_select_fuse), .flash_done(flash_done),
        .flash_start(flash_start), .flash_cmd(flash_cmd), .flash_page(flash_page),
        .cpu_stall(cpu_stall), .rww_read_enable(rww_read_enable),
        .rww_region_busy_flag(rww_region_busy_flag), .spm_refused(spm_refused),
        .spm_busy(spm_busy), .reset_vector(reset_vector), .boot_start(boot_start),
        .boot_lock_bits(boot_lock_bits));
    flash_array_model fam (.clk(clk), .reset(reset), .flash_start(flash_start),
        .flash_page(flash_page), .latency(latency), .flash_done(flash_done),
        .last_page(last_page));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Store-program pulse; start or refusal checked one edge later
    task automatic store_program_memory_op(input logic [12:0] ea, input logic [1:0] cmd, input logic [15:0] ptr,
                       input logic [3:0] ld, input logic go, input logic rf);
        @(posedge clk);
        exec_addr     <= ea;
        spm_cmd       <= cmd;
        spm_pointer   <= ptr;
        spm_lock_data <= ld;
        spm_req       <= 1'b1;
        @(posedge clk);
        spm_req <= 1'b0;
        #1;
        chk(flash_start === go && spm_refused === rf, "store-program answer");
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 300 && spm_busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (spm_busy !== 1'b0) begin
            mismatches++;
            conclude();
        end
    endtask

    // One-cycle pulse of chip erase, flag clear or interface lock write
    task automatic pulse(input logic ce, input logic cl, input logic pl, input logic [3:0] d);
        @(posedge clk);
        chip_erase        <= ce;
        rww_clear_req     <= cl;
        prog_if_lock_req  <= pl;
        prog_if_lock_data <= d;
        @(posedge clk);
        chip_erase       <= 1'b0;
        rww_clear_req    <= 1'b0;
        prog_if_lock_req <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            boot_size_fuses        <= 2'(i % 4);
            boot_reset_select_fuse <= i[0];
            repeat (4) @(posedge clk);
            #1;
            chk(boot_start === bstart[i % 4], "boot start");
            chk(reset_vector === (i[0] ? 13'h0000 : bstart[i % 4]), "reset vector");
        end
        // No READ_WHILE_WRITE_REGION fetches while programming
        store_program_memory_op(13'h1BFF, 2'h0, 16'h0000, 4'hF, 1'b0, 1'b1);
        chk(rww_region_busy_flag === 1'b0, "refusal set flag");
        store_program_memory_op(13'h1C00, 2'h0, 16'h00BE, 4'hF, 1'b1, 1'b0);
        chk(flash_cmd === 2'h0 && flash_page === 7'h01 && cpu_stall === 1'b0, "rww start");
        chk(rww_region_busy_flag === 1'b1 && rww_read_enable === 1'b0, "rww blocked");
        store_program_memory_op(13'h1C02, 2'h1, 16'h3F80, 4'hF, 1'b0, 1'b1);
        chk(flash_page === 7'h01, "page moved");
        pulse(1'b0, 1'b1, 1'b0, 4'hF);
        chk(rww_region_busy_flag === 1'b1, "flag cleared mid op");
        wait_idle();
        chk(last_page === 7'h01 && rww_region_busy_flag === 1'b1, "flag after done");
        pulse(1'b0, 1'b1, 1'b0, 4'hF);
        chk(rww_region_busy_flag === 1'b0 && rww_read_enable === 1'b1, "flag clear");
        latency = 8'h01;
        store_program_memory_op(13'h1C00, 2'h1, 16'h3F80, 4'hF, 1'b1, 1'b0);
        chk(cpu_stall === 1'b1 && rww_region_busy_flag === 1'b0 && flash_page === 7'h7F, "stall");
        chk(flash_cmd === 2'h1 && rww_read_enable === 1'b0, "write start");
        wait_idle();
        chk(cpu_stall === 1'b0 && last_page === 7'h7F, "stall release");
        store_program_memory_op(13'h1C00, 2'h3, 16'h0000, 4'hF, 1'b0, 1'b1);
        latency = 8'h06;
        store_program_memory_op(13'h1C00, 2'h2, 16'h0000, 4'hE, 1'b0, 1'b0);
        chk(boot_lock_bits === 4'hE, "app lock");
        store_program_memory_op(13'h1C00, 2'h0, 16'h0000, 4'hF, 1'b0, 1'b1);
        store_program_memory_op(13'h1C00, 2'h0, 16'h3F00, 4'hF, 1'b1, 1'b0);
        wait_idle();
        pulse(1'b0, 1'b0, 1'b1, 4'hB);
        chk(boot_lock_bits === 4'hA, "boot lock");
        store_program_memory_op(13'h1C00, 2'h0, 16'h3F00, 4'hF, 1'b0, 1'b1);
        pulse(1'b0, 1'b0, 1'b1, 4'hF);
        chk(boot_lock_bits === 4'hA, "lock released by write");
        pulse(1'b1, 1'b0, 1'b0, 4'hF);
        chk(boot_lock_bits === 4'hF, "erase kept locks");
        store_program_memory_op(13'h1C00, 2'h0, 16'h0000, 4'hF, 1'b1, 1'b0);
        wait_idle();
        conclude();
    end
endmodule // tb_top

bind flash_self_program_sections flash_sections_checker chk_i (.clk(clk), .reset(reset),
    .exec_addr(exec_addr), .spm_req(spm_req), .rww_clear_req(rww_clear_req),
    .chip_erase(chip_erase), .flash_start(flash_start), .flash_page(flash_page),
    .cpu_stall(cpu_stall), .rww_read_enable(rww_read_enable),
    .rww_region_busy_flag(rww_region_busy_flag), .spm_refused(spm_refused),
    .spm_busy(spm_busy), .boot_start(boot_start), .boot_lock_bits(boot_lock_bits));
